//--- core/sector_verify_command.sv
// sector verify command handler, 28-bit and 48-bit forms
// Functional notes
// - codes 40h and 41h run the same verify
// - retry bit of the code is ignored
// - code 42h uses 16-bit count, 48-bit address
// - sectors checked, no data phase ever
// - stop at first uncorrectable or idnf sector
// - 28-bit count zero means 256 sectors
// - 48-bit count zero means 65536 sectors
// - chs fields or lba bits 0-7 start
// - cylinder bytes give lba bits 8-23
// - head field gives lba bits 24-27
// - 48-bit address from current and previous bytes
// - return count of sectors left unverified
// - return address of last processed sector
// - 48-bit error address readable by byte select
`timescale 1ns/1ps
`include "verify_map.svh"

module sector_verify_command
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire verify_pkg::taskfile_s tf_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic high_order_byte_select_i,
  input wire logic [7:0] sectors_per_track_i,
  input wire logic [3:0] heads_max_i,
  input wire logic chk_done_i,
  input wire logic chk_unc_i,
  input wire logic chk_idnf_i,
  output verify_pkg::result_s result_o,
  output logic chk_req_o,
  output logic [47:0] chk_addr_o,
  output logic chk_chs_o,
  output logic done_o
);
  import verify_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next sector address; chs layout is {head, cyl_hi, cyl_lo, sector}
  function automatic logic [47:0] advance(input logic [47:0] a, input logic chs,
                                          input logic [7:0] spt, input logic [3:0] hmax);
    logic [47:0] r;
    r = a;
    if (!chs)
      r = a + `ADDR_ONE;
    else if (a[7:0] < spt)
      r[7:0] = a[7:0] + `FIRST_SECTOR;
    else
    begin
      r[7:0] = `FIRST_SECTOR;
      if (a[27:24] < hmax)
        r[27:24] = a[27:24] + 4'h1;
      else
      begin
        r[27:24] = 4'h0;
        r[23:8] = a[23:8] + 16'h0001;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  wire is_28 = (cmd_code_i & `RETRY_IGNORE_MASK) == `VERIFY_CMD_28;
  wire is_ext = cmd_code_i == `VERIFY_CMD_EXT;
  wire lba_mode = tf_i.dev_head[`DEV_LBA_BIT];

  // the 48-bit form only exists in lba mode; chs request is aborted
  wire ext_bad = is_ext && !lba_mode;

  // start count; zero wraps to the full range of each form
  wire [16:0] cnt28 = (tf_i.cnt_cur == 8'h00) ? `COUNT_256 : {9'h000, tf_i.cnt_cur};
  wire [15:0] cnt48_raw = {tf_i.cnt_prev, tf_i.cnt_cur};
  wire [16:0] cnt48 = (cnt48_raw == 16'h0000) ? `COUNT_65536 : {1'b0, cnt48_raw};

  // start address; chs and lba share the same 28-bit packing
  wire [47:0] addr28 = {20'h00000, tf_i.dev_head[`DEV_HEAD_MSB:0],
                        tf_i.ch_cur, tf_i.cl_cur,
                        tf_i.sn_cur};
  wire [47:0] addr48 = {tf_i.ch_prev, tf_i.cl_prev, tf_i.sn_prev,
                        tf_i.ch_cur, tf_i.cl_cur, tf_i.sn_cur};

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  verify_state_e state;
  verify_state_e next_state;
  logic [16:0] remain;
  logic [47:0] addr;
  logic ext;
  logic chs;
  logic unc;
  logic idnf;
  logic abrt;
  logic [3:0] drive_bits;

  wire last_sector = remain == `COUNT_ONE;
  wire bad_sector = chk_unc_i || chk_idnf_i;

  // commands only start while idle; host loads the block first
  wire start = cmd_wr_i && (is_28 || is_ext) && (state == ST_IDLE);

  // state transitions
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start)
          next_state = ext_bad ? ST_FINISH : ST_ISSUE;
      ST_ISSUE:
        next_state = ST_WAIT;
      ST_WAIT:
        if (chk_done_i)
        begin
          if (bad_sector || last_sector)
            next_state = ST_FINISH;
          else
            next_state = ST_ISSUE;
        end
      ST_FINISH:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // count and address tracking

  // address is not advanced past the last or failing sector
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      remain <= 17'h00000;
      addr <= 48'h000000000000;
      ext <= 1'b0;
      chs <= 1'b0;
      drive_bits <= 4'h0;
    end
    else if (state == ST_IDLE && start)
    begin
      remain <= is_ext ? cnt48 : cnt28;
      addr <= is_ext ? addr48 : addr28;
      ext <= is_ext;
      chs <= !lba_mode;
      drive_bits <= tf_i.dev_head[7:4];
    end
    else if (state == ST_WAIT && chk_done_i && !bad_sector && !last_sector)
    begin
      remain <= remain - `COUNT_ONE;
      addr <= advance(addr, chs, sectors_per_track_i, heads_max_i);
    end
    else if (state == ST_WAIT && chk_done_i && !bad_sector)
      remain <= 17'h00000;
  end

  // error flags; unc and idnf cleared by each new command, abrt loaded with ext_bad
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      unc <= 1'b0;
      idnf <= 1'b0;
      abrt <= 1'b0;
    end
    else if (state == ST_IDLE && start)
    begin
      unc <= 1'b0;
      idnf <= 1'b0;
      abrt <= ext_bad;
    end
    else if (state == ST_WAIT && chk_done_i)
    begin
      unc <= chk_unc_i;
      idnf <= chk_idnf_i && !chk_unc_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // media request: one pulse per sector, never a host data phase

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chk_req_o <= 1'b0;
      chk_addr_o <= 48'h000000000000;
      chk_chs_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      chk_req_o <= state == ST_ISSUE;
      chk_addr_o <= addr;
      chk_chs_o <= chs;
      done_o <= state == ST_FINISH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // returned command block

  // busy drops in the finish cycle so the host sees it clear with done
  wire busy = (state != ST_IDLE) && (state != ST_FINISH);
  wire failed = unc || idnf || abrt;
  wire high_order_byte_select = ext && high_order_byte_select_i;

  // status byte; drq is held low for the whole command
  wire [7:0] status_w = ({7'h00, busy} << `ST_BSY) | ({7'h00, !busy} << `ST_RDY)
                        | ({7'h00, !busy} << `ST_DSC)
                        | ({7'h00, !busy && failed} << `ST_ERR);
  wire [7:0] error_w = ({7'h00, unc} << `ER_UNC) | ({7'h00, idnf} << `ER_IDNF)
                       | ({7'h00, abrt} << `ER_ABRT);

  // residual count; low byte only is returned in the 28-bit form
  wire [7:0] count_w = high_order_byte_select ? remain[15:8] : remain[7:0];
  wire [7:0] sn_w = high_order_byte_select ? addr[31:24] : addr[7:0];
  wire [7:0] cl_w = high_order_byte_select ? addr[39:32] : addr[15:8];
  wire [7:0] ch_w = high_order_byte_select ? addr[47:40] : addr[23:16];
  wire [7:0] dh_w = {drive_bits, ext ? 4'h0 : addr[27:24]};

  // registered so the host view is a clean flop
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      result_o <= '0;
    else
    begin
      result_o.status <= status_w;
      result_o.error <= error_w;
      result_o.count <= count_w;
      result_o.sector_num <= sn_w;
      result_o.cyl_low <= cl_w;
      result_o.cyl_high <= ch_w;
      result_o.dev_head <= dh_w;
    end
  end

endmodule

//--- include/verify_map.svh
// command codes, field positions and status/error bit positions for the verify handler
`ifndef VERIFY_MAP_SVH
`define VERIFY_MAP_SVH

`define VERIFY_CMD_28 8'h40
`define VERIFY_CMD_EXT 8'h42
`define RETRY_IGNORE_MASK 8'hfe

`define DEV_LBA_BIT 6
`define DEV_DRIVE_BIT 4
`define DEV_HEAD_MSB 3

`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0

`define ER_UNC 6
`define ER_IDNF 4
`define ER_ABRT 2

`define COUNT_ONE 17'h00001
`define COUNT_256 17'h00100
`define COUNT_65536 17'h10000
`define FIRST_SECTOR 8'h01
`define ADDR_ONE 48'h000000000001

`endif

//--- include/verify_pkg.sv
// types shared by the sector verify handler and its bench
package verify_pkg;

  // command block written by the host, current and previous bytes
  typedef struct packed {
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] sn_cur;
    logic [7:0] sn_prev;
    logic [7:0] cl_cur;
    logic [7:0] cl_prev;
    logic [7:0] ch_cur;
    logic [7:0] ch_prev;
    logic [7:0] dev_head;
  } taskfile_s;

  // command block returned to the host
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] count;
    logic [7:0] sector_num;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] dev_head;
  } result_s;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_FINISH = 4'b1000
  } verify_state_e;

endpackage

//--- sim/media_model.sv
// media engine stand-in, answers each sector check after a set lag
`timescale 1ns/1ps
module media_model
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [47:0] addr_i,
  input wire logic [47:0] bad_i,
  input wire logic nf_i,
  input wire logic [3:0] lag_i,
  output logic done_o,
  output logic unc_o,
  output logic idnf_o
);
  logic [4:0] cnt;
  logic hit;
  // one sector in flight; fault flags stay low outside the done pulse
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= 5'h00;
      done_o <= 1'h0;
      hit <= 1'h0;
    end
    else
    begin
      done_o <= cnt == 5'h01;
      if (req_i)
        cnt <= {1'h0, lag_i} + 5'h01;
      else if (cnt != 5'h00)
        cnt <= cnt - 5'h01;
      if (req_i)
        hit <= addr_i == bad_i;
    end
  end
  assign unc_o = done_o & hit & ~nf_i;
  assign idnf_o = done_o & hit & nf_i;
endmodule

//--- sim/sector_verify_command_assertions.sv
// port checker for the sector verify handler
`timescale 1ns/1ps
module sector_verify_command_assertions
  import verify_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire verify_pkg::taskfile_s tf_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic chk_done_i,
  input wire logic chk_unc_i,
  input wire logic chk_idnf_i,
  input wire verify_pkg::result_s result_o,
  input wire logic chk_req_o,
  input wire logic [47:0] chk_addr_o,
  input wire logic chk_chs_o,
  input wire logic done_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [47:0] prev;
  logic first;
  // decoded views of the command block
  wire busy = result_o.status[7];
  wire [47:0] a28 = {20'h0, tf_i.dev_head[3:0], tf_i.ch_cur, tf_i.cl_cur, tf_i.sn_cur};
  wire [47:0] a48 = {tf_i.ch_prev, tf_i.cl_prev, tf_i.sn_prev,
                     tf_i.ch_cur, tf_i.cl_cur, tf_i.sn_cur};
  sequence s_bad;
    chk_done_i && busy && (chk_unc_i || chk_idnf_i);
  endsequence
  // first request of a command has no predecessor to step from
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      first <= 1'h1;
    else if (done_o || chk_req_o)
      first <= done_o;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (chk_req_o)
      prev <= chk_addr_o;
  end
  a_no_data_phase: assert property (result_o.status[3] == 1'h0)
    else $error("data request flag set");
  a_start_short: assert property (
    cmd_wr_i && cmd_code_i[7:1] == 7'h20 && !busy
    |-> ##2 busy && chk_req_o && chk_addr_o == $past(a28, 2)
    && chk_chs_o == !$past(tf_i.dev_head[6], 2)) else $error("bad 28-bit start");
  a_start_long: assert property (
    cmd_wr_i && cmd_code_i == 8'h42 && tf_i.dev_head[6] && !busy
    |-> ##2 chk_req_o && chk_addr_o == $past(a48, 2)) else $error("bad 48-bit start");
  a_done_idle: assert property (done_o |-> !busy && result_o.status[6])
    else $error("busy at end");
  a_err_flag: assert property (done_o |-> result_o.status[0] == |result_o.error)
    else $error("error flag wrong");
  a_ok_count: assert property (done_o && !result_o.status[0] |-> result_o.count == 8'h00)
    else $error("count left on success");
  a_stop_at_bad: assert property (s_bad |=> !chk_req_o ##1 (done_o && !chk_req_o))
    else $error("no stop at bad sector");
  a_next_sector: assert property (chk_done_i && busy && !chk_unc_i && !chk_idnf_i
    |-> ##2 (chk_req_o != done_o)) else $error("no next step");
  a_lba_step: assert property (
    chk_req_o && !first && !chk_chs_o |-> chk_addr_o == prev + 48'h1)
    else $error("address not consecutive");
endmodule
bind sector_verify_command sector_verify_command_assertions u_sector_verify_command_assertions
  (.sys_clk_i, .rst_n_i, .tf_i, .cmd_wr_i, .cmd_code_i, .chk_done_i, .chk_unc_i, .chk_idnf_i,
  .result_o, .chk_req_o, .chk_addr_o, .chk_chs_o, .done_o);

//--- sim/tb_top.sv
// self-checking bench for the sector verify handler
`timescale 1ns/1ps
module tb_top;
  import verify_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic wr = 1'h0;
  logic high_order_byte_select = 1'h0;
  logic nf = 1'h0;
  logic [7:0] code = 8'h00;
  logic [3:0] lag = 4'h0;
  logic [47:0] bad = 48'hffffffffffff;
  taskfile_s tf = '0;
  result_s res;
  logic req, chs, done, cd, cu, ci;
  logic [47:0] addr;
  int num_errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  sector_verify_command u_sector_verify_command (.sys_clk_i(clk), .rst_n_i(rst_n), .tf_i(tf),
    .cmd_wr_i(wr), .cmd_code_i(code), .high_order_byte_select_i(high_order_byte_select),
    .sectors_per_track_i(8'h3f), .heads_max_i(4'hf), .chk_done_i(cd), .chk_unc_i(cu),
    .chk_idnf_i(ci), .result_o(res), .chk_req_o(req), .chk_addr_o(addr), .chk_chs_o(chs),
    .done_o(done));
  media_model u_media_model (.sys_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .addr_i(addr),
    .bad_i(bad), .nf_i(nf), .lag_i(lag), .done_o(cd), .unc_o(cu), .idnf_o(ci));
  //////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [55:0] e);
    n_checks++;
    if (res !== e)
    begin
      num_errors++;
      $display("unexpected result exp %h got %h", e, res);
    end
  endtask
  // block is loaded whole on the same negedge as the code and wr, then held until the end
  task run(input string n, input logic [7:0] c, input taskfile_s t);
    int i;
    @(negedge clk);
    tf = t;
    code = c;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    for (i = 0; i < 3000 && done !== 1'h1; i++)
      @(negedge clk);
    if (done !== 1'h1)
    begin
      num_errors++;
      $display("unexpected done_o in %s exp 1 got 0", n);
      results();
    end
    $display("test %s ended", n);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    run("lba", 8'h41, 72'h03_00_56_00_34_00_12_00_45);
    chk(56'h50_00_00_58_34_12_45);
    lag = 4'h3;
    bad = 48'h00000512345b;
    run("count0", 8'h40, 72'h00_00_56_00_34_00_12_00_45);
    chk(56'h51_40_fb_5b_34_12_45);
    lag = 4'h8;
    nf = 1'h1;
    bad = 48'h665544332214;
    run("ext", 8'h42, 72'h00_00_11_44_22_55_33_66_40);
    chk(56'h51_10_fd_14_22_33_40);
    high_order_byte_select = 1'h1;
    repeat (2) @(negedge clk);
    chk(56'h51_10_ff_44_55_66_40);
    high_order_byte_select = 1'h0;
    lag = 4'h0;
    run("chs", 8'h40, 72'h02_00_3f_00_10_00_00_00_02);
    chk(56'h50_00_00_01_10_00_03);
    high_order_byte_select = 1'h1;
    repeat (2) @(negedge clk);
    chk(56'h50_00_00_01_10_00_03);
    high_order_byte_select = 1'h0;
    run("abort", 8'h42, 72'h00_00_11_00_22_00_33_00_00);
    chk(56'h51_04_00_11_22_33_00);
    results();
  end
endmodule
